// [flash_pins_pkg.sv]
// constants, enumerations and carriers for the serial flash pin interface
package flash_pins_pkg;
    localparam int CLK_SYS_PERIOD_NS = 40;
    localparam int RESET_PULSE_MIN_WIDTH_NS = 1000;
    localparam int RESET_PULSE_CYCLES =
        (RESET_PULSE_MIN_WIDTH_NS + CLK_SYS_PERIOD_NS - 1) / CLK_SYS_PERIOD_NS;
    localparam int RST_CNT_W = 5;
    localparam logic [RST_CNT_W-1:0] RST_CNT_DONE = RST_CNT_W'(RESET_PULSE_CYCLES - 1);
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] STEP_SINGLE = 4'h1;
    localparam logic [3:0] STEP_DUAL = 4'h2;
    localparam logic [3:0] STEP_QUAD = 4'h4;
    localparam logic [3:0] OE_SINGLE = 4'h2;
    localparam logic [3:0] OE_DUAL = 4'h3;
    localparam logic [3:0] OE_QUAD = 4'hF;
    localparam logic [1:0] ADDR_LAST_BYTE = 2'h2;
    localparam logic [7:0] INDEX_MAX = 8'hFF;
    localparam logic [23:0] LINEAR_MASK = 24'hFFFFFF;
    localparam logic [23:0] WRAP8_MASK = 24'h000007;
    localparam logic [23:0] WRAP16_MASK = 24'h00000F;
    localparam logic [23:0] WRAP32_MASK = 24'h00001F;
    localparam logic [23:0] WRAP64_MASK = 24'h00003F;
    localparam logic [23:0] SECTOR_4K_MASK = 24'h000FFF;
    localparam logic [23:0] BLOCK_32K_MASK = 24'h007FFF;
    localparam logic [23:0] BLOCK_64K_MASK = 24'h00FFFF;

    typedef enum logic [1:0] {
        WIDTH_SINGLE = 2'b00,
        WIDTH_DUAL = 2'b01,
        WIDTH_QUAD = 2'b10
    } width_type;

    typedef enum logic [1:0] {
        WRAP_8 = 2'b00,
        WRAP_16 = 2'b01,
        WRAP_32 = 2'b10,
        WRAP_64 = 2'b11
    } wrap_type;

    typedef enum logic [1:0] {
        ERASE_SECTOR_4K = 2'b00,
        ERASE_BLOCK_32K = 2'b01,
        ERASE_BLOCK_64K = 2'b10
    } erase_type;

    typedef enum logic [1:0] {
        FRAME_IDLE = 2'b00,
        FRAME_INSTR = 2'b01,
        FRAME_ADDR = 2'b10,
        FRAME_DATA = 2'b11
    } frame_state_type;

    typedef struct packed {
        logic quad_enable_bit;
        logic pin_function_select_bit;
        logic status_protect_bit;
        logic four_wire_command_mode;
        logic continuous_read_mode;
        logic wrap_enable;
        wrap_type wrap_size;
        erase_type erase_kind;
    } cfg_type;

    typedef struct packed {
        width_type rx_width;
        width_type tx_width;
        logic tx_active;
        logic uid_select;
    } phase_type;

    typedef struct packed {
        logic valid;
        logic is_instruction;
        logic [7:0] index;
        logic [7:0] data;
    } rx_type;
endpackage

// [serial_flash_pin_interface.sv]
// pin-level serial flash interface: edge sampling, lane sharing, pause and hardware reset
`timescale 1ns/10ps
module serial_flash_pin_interface #(
    parameter logic [63:0] UNIQUE_ID = 64'h0123456789ABCDEF // arbitrary value
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic spi_clk,
    input wire logic chip_select_n,
    input wire logic [3:0] data_line_in,
    output logic [3:0] data_line_out,
    output logic [3:0] data_line_oe,
    input flash_pins_pkg::cfg_type cfg,
    input flash_pins_pkg::phase_type phase,
    input wire logic [7:0] tx_data,
    input wire logic [7:0] prog_old_byte,
    output flash_pins_pkg::rx_type rx,
    output logic [23:0] address,
    output logic address_valid,
    output logic [23:0] read_address,
    output logic [23:0] erase_base,
    output logic tx_take,
    output logic [7:0] page_column,
    output logic [7:0] prog_result,
    output logic status_write_allowed,
    output logic selected,
    output logic paused,
    output logic hw_reset
);
    import flash_pins_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic sck_s1, sck_s2, sck_d;
    logic cs_s1, cs_s2, cs_d;
    logic [3:0] dl_s1, dl_s2;
    logic armed;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_d <= 1'b0;
            cs_s1 <= 1'b0;
            cs_s2 <= 1'b0;
            cs_d <= 1'b0;
            dl_s1 <= 4'h0;
            dl_s2 <= 4'h0;
        end else if (clk_en) begin
            sck_s1 <= spi_clk;
            sck_s2 <= sck_s1;
            sck_d <= sck_s2;
            cs_s1 <= chip_select_n;
            cs_s2 <= cs_s1;
            cs_d <= cs_s2;
            dl_s1 <= data_line_in;
            dl_s2 <= dl_s1;
        end
    end

    // first falling chip select after reset arms the port
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            armed <= 1'b0;
        end else if (clk_en && cs_d && !cs_s2) begin
            armed <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // shared pin functions
    logic hold_func, reset_func, active, rise, fall;
    logic [RST_CNT_W-1:0] rst_cnt;

    assign hold_func = !cfg.quad_enable_bit && !cfg.pin_function_select_bit;
    assign reset_func = !cfg.quad_enable_bit && cfg.pin_function_select_bit;
    assign active = armed && !cs_s2 && !paused && !hw_reset;
    assign rise = active && sck_s2 && !sck_d;
    assign fall = active && !sck_s2 && sck_d;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            paused <= 1'b0;
            selected <= 1'b0;
            status_write_allowed <= 1'b1;
        end else if (clk_en) begin
            paused <= hold_func && !dl_s2[3] && !cs_s2 && armed;
            selected <= armed && !cs_s2;
            status_write_allowed <= cfg.quad_enable_bit ||
                !(cfg.status_protect_bit && !dl_s2[2]);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_cnt <= '0;
            hw_reset <= 1'b0;
        end else if (clk_en) begin
            if (reset_func && !dl_s2[3]) begin
                if (rst_cnt != RST_CNT_DONE) begin
                    rst_cnt <= rst_cnt + 1'b1;
                end
            end else begin
                rst_cnt <= '0;
            end
            hw_reset <= reset_func && !dl_s2[3] && (rst_cnt == RST_CNT_DONE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive path
    frame_state_type state;
    width_type rx_w;
    logic [3:0] rx_cnt, step, next_cnt;
    logic [7:0] rx_sr, next_rx_sr, byte_idx, prog_cnt;
    logic [1:0] addr_cnt;
    logic [15:0] addr_sr;
    logic [23:0] erase_mask, new_addr;

    always_comb begin
        // instruction byte in four-wire-command mode always uses four lines
        rx_w = (state == FRAME_INSTR && cfg.four_wire_command_mode) ?
            WIDTH_QUAD : phase.rx_width;
        unique case (rx_w)
            WIDTH_DUAL: begin
                step = STEP_DUAL;
                next_rx_sr = {rx_sr[5:0], dl_s2[1:0]};
            end
            WIDTH_QUAD: begin
                step = STEP_QUAD;
                next_rx_sr = {rx_sr[3:0], dl_s2};
            end
            default: begin
                step = STEP_SINGLE;
                next_rx_sr = {rx_sr[6:0], dl_s2[0]};
            end
        endcase
        next_cnt = rx_cnt + step;
        unique case (cfg.erase_kind)
            ERASE_BLOCK_32K: erase_mask = BLOCK_32K_MASK;
            ERASE_BLOCK_64K: erase_mask = BLOCK_64K_MASK;
            default: erase_mask = SECTOR_4K_MASK;
        endcase
        new_addr = {addr_sr, next_rx_sr};
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= FRAME_IDLE;
            rx_cnt <= 4'h0;
            rx_sr <= 8'h00;
            byte_idx <= 8'h00;
            addr_cnt <= 2'h0;
            addr_sr <= 16'h0000;
            prog_cnt <= 8'h00;
            rx <= '0;
            address <= 24'h000000;
            address_valid <= 1'b0;
            erase_base <= 24'h000000;
            page_column <= 8'h00;
            prog_result <= 8'hFF;
        end else if (clk_en) begin
            rx.valid <= 1'b0;
            address_valid <= 1'b0;
            if (cs_s2 || hw_reset || !armed) begin
                state <= FRAME_IDLE;
                rx_cnt <= 4'h0;
                byte_idx <= 8'h00;
                addr_cnt <= 2'h0;
                prog_cnt <= 8'h00;
            end else if (state == FRAME_IDLE) begin
                state <= cfg.continuous_read_mode ? FRAME_ADDR : FRAME_INSTR;
            end else if (rise && !phase.tx_active) begin
                // paused cycles never reach here, so position is kept
                rx_sr <= next_rx_sr;
                rx_cnt <= next_cnt;
                if (next_cnt == BITS_PER_BYTE) begin
                    rx_cnt <= 4'h0;
                    rx.valid <= 1'b1;
                    rx.data <= next_rx_sr;
                    rx.index <= byte_idx;
                    rx.is_instruction <= (state == FRAME_INSTR);
                    if (byte_idx != INDEX_MAX) begin
                        byte_idx <= byte_idx + 1'b1;
                    end
                    unique case (state)
                        FRAME_INSTR: state <= FRAME_ADDR;
                        FRAME_ADDR: begin
                            addr_sr <= {addr_sr[7:0], next_rx_sr};
                            addr_cnt <= addr_cnt + 1'b1;
                            if (addr_cnt == ADDR_LAST_BYTE) begin
                                state <= FRAME_DATA;
                                address <= new_addr;
                                address_valid <= 1'b1;
                                erase_base <= new_addr & ~erase_mask;
                            end
                        end
                        default: begin
                            // column wraps inside the 256-byte page
                            page_column <= address[7:0] + prog_cnt;
                            prog_cnt <= prog_cnt + 1'b1;
                            prog_result <= prog_old_byte & next_rx_sr;
                        end
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmit path
    logic [3:0] tx_cnt, tx_step, tx_oe;
    logic [7:0] tx_sr, cur, src, uid_byte;
    logic [2:0] uid_idx;
    logic [23:0] wrap_mask, next_read;

    always_comb begin
        uid_byte = UNIQUE_ID[{~uid_idx, 3'b000} +: 8];
        src = phase.uid_select ? uid_byte : tx_data;
        cur = (tx_cnt == 4'h0) ? src : tx_sr;
        unique case (phase.tx_width)
            WIDTH_DUAL: begin
                tx_step = STEP_DUAL;
                tx_oe = OE_DUAL;
            end
            WIDTH_QUAD: begin
                tx_step = STEP_QUAD;
                tx_oe = OE_QUAD;
            end
            default: begin
                tx_step = STEP_SINGLE;
                tx_oe = OE_SINGLE;
            end
        endcase
        unique case (cfg.wrap_size)
            WRAP_8: wrap_mask = WRAP8_MASK;
            WRAP_16: wrap_mask = WRAP16_MASK;
            WRAP_32: wrap_mask = WRAP32_MASK;
            WRAP_64: wrap_mask = WRAP64_MASK;
        endcase
        if (!cfg.wrap_enable) begin
            wrap_mask = LINEAR_MASK;
        end
        next_read = (read_address & ~wrap_mask) |
            ((read_address + 24'h000001) & wrap_mask);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_cnt <= 4'h0;
            tx_sr <= 8'h00;
            uid_idx <= 3'h0;
            tx_take <= 1'b0;
            read_address <= 24'h000000;
            data_line_out <= 4'h0;
            data_line_oe <= 4'h0;
        end else if (clk_en) begin
            tx_take <= 1'b0;
            if (address_valid) begin
                read_address <= address;
            end
            if (cs_s2 || hw_reset || !armed) begin
                tx_cnt <= 4'h0;
                uid_idx <= 3'h0;
                data_line_oe <= 4'h0;
            end else if (paused) begin
                data_line_oe <= 4'h0;
            end else if (fall && phase.tx_active) begin
                data_line_oe <= tx_oe;
                unique case (phase.tx_width)
                    WIDTH_DUAL: data_line_out <= {2'b00, cur[7:6]};
                    WIDTH_QUAD: data_line_out <= cur[7:4];
                    default: data_line_out <= {2'b00, cur[7], 1'b0};
                endcase
                tx_sr <= cur << tx_step;
                tx_cnt <= (tx_cnt + tx_step == BITS_PER_BYTE) ? 4'h0 : tx_cnt + tx_step;
                if (tx_cnt == 4'h0) begin
                    tx_take <= 1'b1;
                    uid_idx <= uid_idx + 1'b1;
                    if (!address_valid) begin
                        read_address <= next_read;
                    end
                end
            end else if (!phase.tx_active) begin
                data_line_oe <= 4'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    AST_OE_OFF_DESELECT: assert property (
        clk_en && cs_s2 |=> data_line_oe == 4'h0)
        else $error("outputs driven while deselected");
    AST_NO_RX_UNARMED: assert property (
        !armed |=> !rx.valid)
        else $error("byte received before first chip select fall");
    AST_PAUSE_FREEZE: assert property (
        paused && clk_en && !cs_s2 |=> data_line_oe == 4'h0 && $stable(rx_cnt))
        else $error("activity while paused");
    AST_QUAD_NO_PAUSE_RESET: assert property (
        cfg.quad_enable_bit && clk_en |=> !paused && !hw_reset)
        else $error("pause or reset active in quad mode");
    AST_RESET_WIDTH: assert property (
        $rose(hw_reset) |-> $past(rst_cnt) == RST_CNT_DONE)
        else $error("hardware reset taken before minimum width");
    AST_WP_BLOCK: assert property (
        clk_en && !cfg.quad_enable_bit && cfg.status_protect_bit && !dl_s2[2]
        |=> !status_write_allowed)
        else $error("status write allowed under write protect");
    AST_QPI_TWO_CLOCKS: assert property (
        clk_en && rise && !phase.tx_active && state == FRAME_INSTR &&
        cfg.four_wire_command_mode && rx_cnt == STEP_QUAD
        |=> rx.valid && rx.is_instruction)
        else $error("four-wire instruction not complete after two clocks");
    AST_SINGLE_BYTE: assert property (
        clk_en && rise && !phase.tx_active && rx_w == WIDTH_SINGLE && rx_cnt == 4'h7
        |=> rx.valid)
        else $error("single-bit byte not complete after eight rising edges");
    AST_TX_ON_FALL: assert property (
        $changed(data_line_out) |-> $past(fall))
        else $error("output data changed outside a falling edge");
    AST_WRAP_WINDOW: assert property (
        tx_take && !address_valid && cfg.wrap_enable && cfg.wrap_size == WRAP_8
        |-> read_address[23:3] == $past(read_address[23:3]))
        else $error("read address left its wrap window");
endmodule

// [spi_host_model.sv]
// host-side model of the serial link: clock, chip select and host data drive
`timescale 1ns/10ps
module spi_host_model (
    input wire logic clk_sys,
    input wire logic [3:0] line_level,
    output logic spi_clk,
    output logic chip_select_n,
    output logic [3:0] host_out,
    output logic [3:0] host_oe
);
    localparam int HALF = 4;

    ////////////////////////////////////////////////////////////////////////
    // already selected at power-up, before any falling edge
    initial begin
        spi_clk = 1'b0;
        chip_select_n = 1'b0;
        host_out = 4'h0;
        host_oe = 4'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // chip select first, clock parked low afterwards so no edge is seen selected
    task automatic set_cs(input logic level);
        @(posedge clk_sys);
        #1;
        chip_select_n = level;
        host_oe = 4'h0;
        repeat (HALF) @(posedge clk_sys);
        #1;
        spi_clk = 1'b0;
        repeat (HALF) @(posedge clk_sys);
        #1;
    endtask

    // one serial clock: fall with new drive, then rise with the lines sampled
    task automatic cycle(input logic [3:0] drive, input logic [3:0] en,
                         output logic [3:0] seen);
        @(posedge clk_sys);
        #1;
        spi_clk = 1'b0;
        host_out = drive;
        host_oe = en;
        repeat (HALF) @(posedge clk_sys);
        #1;
        seen = line_level;
        spi_clk = 1'b1;
        repeat (HALF - 1) @(posedge clk_sys);
        #1;
    endtask
endmodule

// [serial_flash_pin_interface_tb.sv]
// self-checking bench for the serial flash pin interface
`timescale 1ns/10ps
module serial_flash_pin_interface_tb;
    import flash_pins_pkg::*;
    localparam logic [63:0] UID = 64'h1122334455667788; // arbitrary value
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic spi_clk, chip_select_n, address_valid, tx_take;
    logic status_write_allowed, selected, paused, hw_reset;
    logic [3:0] dout, doe, h_out, h_oe, line;
    logic [3:0] flt = 4'h5;
    logic [3:0] pin_out = 4'hF;
    logic [3:0] pin_oe = 4'hC;
    cfg_type cfg = '0;
    phase_type phase = '0;
    logic [7:0] tx_data = 8'hA5;
    logic [7:0] prog_old_byte = 8'hF0;
    logic [7:0] page_column, prog_result;
    logic [23:0] address, read_address, erase_base;
    rx_type rx;
    logic [7:0] rx_q[$];
    int instr_cnt = 0;
    int take_cnt = 0;
    int av_cnt = 0;
    logic [7:0] last_idx = 8'h00;
    int cyc = 0;
    int error_cnt = 0;
    int tests_run = 0;

    // undriven lines show a pattern that changes every cycle
    assign line = (dout & doe) | (h_out & h_oe) | (pin_out & pin_oe) | (flt & ~(doe | h_oe | pin_oe));

    always #20 clk_sys = ~clk_sys;

    spi_host_model u_spi_host_model (.clk_sys(clk_sys), .line_level(line), .spi_clk(spi_clk),
        .chip_select_n(chip_select_n), .host_out(h_out), .host_oe(h_oe));

    serial_flash_pin_interface #(.UNIQUE_ID(UID)) u_serial_flash_pin_interface (
        .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .spi_clk(spi_clk),
        .chip_select_n(chip_select_n), .data_line_in(line), .data_line_out(dout),
        .data_line_oe(doe), .cfg(cfg), .phase(phase), .tx_data(tx_data),
        .prog_old_byte(prog_old_byte), .rx(rx), .address(address),
        .address_valid(address_valid), .read_address(read_address), .erase_base(erase_base),
        .tx_take(tx_take), .page_column(page_column), .prog_result(prog_result),
        .status_write_allowed(status_write_allowed), .selected(selected), .paused(paused),
        .hw_reset(hw_reset));

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys) begin
        flt <= ~flt;
        cyc <= cyc + 1;
        if (tx_take === 1'b1) take_cnt <= take_cnt + 1;
        if (address_valid === 1'b1) av_cnt <= av_cnt + 1;
        if (rx.valid === 1'b1) begin
            rx_q.push_back(rx.data);
            last_idx <= rx.index;
            if (rx.is_instruction === 1'b1) instr_cnt <= instr_cnt + 1;
        end
        if (cyc == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    function automatic int lanes(input width_type w);
        return (w == WIDTH_QUAD) ? 4 : (w == WIDTH_DUAL) ? 2 : 1;
    endfunction

    // msb first; dual puts the higher bit on line one
    task automatic send_byte(input logic [7:0] b, input width_type w, input int cnt = 0);
        logic [3:0] seen;
        logic [7:0] s;
        int n;
        n = lanes(w);
        s = b;
        if (cnt == 0) cnt = 8 / n;
        for (int i = 0; i < cnt; i++) begin
            u_spi_host_model.cycle(s[7:4] >> (4 - n), (4'h1 << n) - 4'h1, seen);
            s = s << n;
        end
    endtask

    task automatic recv_byte(input width_type w, output logic [7:0] b);
        logic [3:0] seen;
        int n;
        n = lanes(w);
        b = 8'h00;
        for (int i = 0; i < 8 / n; i++) begin
            u_spi_host_model.cycle(4'h0, 4'h0, seen);
            if (i == 0) check(doe, (n == 4) ? 4'hF : (n == 2) ? 4'h3 : 4'h2);
            if (n == 1) b = {b[6:0], seen[1]};
            else if (n == 2) b = {b[5:0], seen[1:0]};
            else b = {b[3:0], seen};
        end
    endtask

    task automatic frame(input logic instr, input width_type w, input logic [23:0] a);
        u_spi_host_model.set_cs(1'b0);
        if (instr) send_byte(8'h6B, cfg.four_wire_command_mode ? WIDTH_QUAD : WIDTH_SINGLE);
        phase.rx_width = w;
        for (int i = 2; i >= 0; i--) send_byte(a[i * 8 +: 8], w);
    endtask

    task automatic close_frame();
        u_spi_host_model.set_cs(1'b1);
        phase = '0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] got;
        wait_cyc(16);
        rst_n = 1'b1;
        send_byte(8'h9F, WIDTH_SINGLE);
        wait_cyc(8);
        check(rx_q.size(), 0);
        check(selected, 1'b0);
        close_frame();
        $display("test arming done");
        for (int k = 0; k < 3; k++) begin
            cfg.erase_kind = erase_type'(k);
            cfg.quad_enable_bit = (k == 2);
            pin_oe = (k == 2) ? 4'h0 : 4'hC;
            rx_q.delete();
            frame(1'b1, width_type'(k), 24'h12B4FF);
            send_byte(8'hC3, width_type'(k));
            send_byte(8'h3C, width_type'(k));
            wait_cyc(8);
            check(rx_q.size(), 6);
            check(last_idx, 8'h05);
            check({rx_q[0], rx_q[4], rx_q[5]}, {8'h6B, 8'hC3, 8'h3C});
            check(address, 24'h12B4FF);
            check(erase_base, (k == 0) ? 24'h12B000 : (k == 1) ? 24'h128000 : 24'h120000);
            check(page_column, 8'h00);
            check(prog_result, 8'h30);
            close_frame();
        end
        $display("test receive widths done");
        cfg.wrap_enable = 1'b1;
        for (int k = 0; k < 4; k++) begin
            cfg.wrap_size = wrap_type'(k);
            cfg.four_wire_command_mode = (k == 0);
            cfg.continuous_read_mode = (k % 2 == 1);
            tx_data = 8'h5A + 8'(k);
            frame(k % 2 == 0, WIDTH_QUAD, 24'h00FF3F);
            phase.tx_width = WIDTH_QUAD;
            phase.tx_active = 1'b1;
            recv_byte(WIDTH_QUAD, got);
            check(got, 8'h5A + 8'(k));
            check(read_address, 24'h00FF3F & ~((24'h8 << k) - 24'h1));
            close_frame();
        end
        check(instr_cnt, 5);
        check(av_cnt, 7);
        $display("test quad wrap done");
        cfg = '0;
        pin_oe = 4'hC;
        frame(1'b1, WIDTH_SINGLE, 24'h000000);
        check(selected, 1'b1);
        phase.tx_active = 1'b1;
        phase.uid_select = 1'b1;
        recv_byte(WIDTH_SINGLE, got);
        check(got, UID[63:56]);
        pin_out[3] = 1'b0;
        wait_cyc(8);
        check(paused, 1'b1);
        check(doe, 4'h0);
        pin_out[3] = 1'b1;
        wait_cyc(8);
        recv_byte(WIDTH_SINGLE, got);
        check(got, UID[55:48]);
        check(take_cnt, 6);
        close_frame();
        check(doe, 4'h0);
        check(selected, 1'b0);
        $display("test unique id done");
        rx_q.delete();
        u_spi_host_model.set_cs(1'b0);
        send_byte(8'h96, WIDTH_SINGLE, 4);
        pin_out[3] = 1'b0;
        wait_cyc(8);
        check(paused, 1'b1);
        check(doe, 4'h0);
        send_byte(8'hFF, WIDTH_SINGLE, 4);
        pin_out[3] = 1'b1;
        wait_cyc(8);
        check(paused, 1'b0);
        send_byte(8'h60, WIDTH_SINGLE, 4);
        wait_cyc(8);
        check(rx_q.size(), 1);
        check(rx_q[0], 8'h96);
        $display("test pause done");
        cfg.pin_function_select_bit = 1'b1;
        rx_q.delete();
        send_byte(8'h42, WIDTH_SINGLE, 4);
        pin_out[3] = 1'b0;
        wait_cyc(20);
        pin_out[3] = 1'b1;
        wait_cyc(6);
        check(hw_reset, 1'b0);
        pin_out[3] = 1'b0;
        wait_cyc(30);
        check(hw_reset, 1'b1);
        pin_out[3] = 1'b1;
        wait_cyc(6);
        check(hw_reset, 1'b0);
        send_byte(8'h20, WIDTH_SINGLE, 4);
        wait_cyc(8);
        check(rx_q.size(), 0);
        cfg.quad_enable_bit = 1'b1;
        pin_out[3] = 1'b0;
        wait_cyc(40);
        check(hw_reset, 1'b0);
        cfg.pin_function_select_bit = 1'b0;
        wait_cyc(6);
        check(paused, 1'b0);
        pin_out[3] = 1'b1;
        close_frame();
        $display("test hardware reset done");
        for (int k = 0; k < 4; k++) begin
            cfg.quad_enable_bit = (k == 3);
            cfg.status_protect_bit = (k != 2);
            pin_out[2] = (k == 1);
            wait_cyc(6);
            check(status_write_allowed, k != 0);
        end
        $display("test write protect done");
        report_and_stop();
    end
endmodule
